/* include/pee_pkg.sv */
// constants for the paged eeprom host controller
package pee_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  localparam int POLL_BIT = 7;
  // write pulse width, ns
  localparam int WP_NS = 100;
  localparam int WP_CYC = (WP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // write pulse high, ns
  localparam int WPH_NS = 50;
  localparam int WPH_CYC0 = (WPH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WPH_CYC = (WPH_CYC0 < 1) ? 1 : WPH_CYC0;
  // read access, ns
  localparam int ACC_NS = 150;
  localparam int ACC_CYC = (ACC_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
  // byte load window, us (longest time, rounds down)
  localparam int BLC_US = 150;
  localparam int BLC_CYC = BLC_US * (CLK_HZ / 1000000);
  // erase strobe, ms
  localparam int ERASE_MS = 10;
  localparam int ERASE_CYC = ERASE_MS * (CLK_HZ / 1000);
  // erase setup/hold, us
  localparam int ERSH_US = 5;
  localparam int ERSH_CYC = ERSH_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 24;
  typedef enum logic [3:0] {
    PEE_IDLE, PEE_RD_WAIT, PEE_WR_LOW, PEE_WR_HIGH, PEE_POLL_LOW, PEE_POLL_CHK,
    PEE_ER_SETUP, PEE_ER_LOW, PEE_ER_HOLD
  } pee_state_t;
endpackage

/* rtl/pee_sync.sv */
// two flip-flop synchroniser for the data pins
`timescale 1ns/10ps
module pee_sync
  import pee_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;
  always_comb
  begin
    next_meta = d_in;
    next_q = meta;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end
endmodule

/* rtl/pee_host.sv */
// host controller driving a paged parallel eeprom through its pins
`timescale 1ns/10ps
module pee_host
  import pee_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int POLL_LIMIT = 4000000
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // user request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_last_in,
  input wire logic req_erase_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic wr_done_out,
  output logic err_out,
  // device pins
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic chip_en_n_out,
  output logic out_en_n_out,
  output logic write_en_n_out,
  output logic erase_hv_out,
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_out
);
  logic rst_m;
  logic rst_n;
  logic [DATA_W-1:0] pin_data;
  pee_state_t state;
  pee_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] blc_cnt;
  logic [CNT_W-1:0] next_blc_cnt;
  logic [31:0] poll_cnt;
  logic [31:0] next_poll_cnt;
  logic loading;
  logic next_loading;
  logic [ADDR_W-PAGE_LSB-1:0] page;
  logic [ADDR_W-PAGE_LSB-1:0] next_page;
  logic [ADDR_W-1:0] last_addr;
  logic [ADDR_W-1:0] next_last_addr;
  logic last_bit;
  logic next_last_bit;
  logic next_ready;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rdata;
  logic next_done;
  logic next_err;
  logic [ADDR_W-1:0] next_addr;
  logic next_ce_n;
  logic next_oe_n;
  logic next_we_n;
  logic next_hv;
  logic [DATA_W-1:0] next_dout;
  logic next_doe;
  logic page_ok;

  // reset release through two flops
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // data pins come from the device, unclocked
  pee_sync #(.WIDTH(DATA_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .d_in(mem_data_in),
    .q_out(pin_data)
  );

  assign page_ok = !loading || (req_addr_in[ADDR_W-1:PAGE_LSB] == page);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_blc_cnt = blc_cnt;
    next_poll_cnt = poll_cnt;
    next_loading = loading;
    next_page = page;
    next_last_addr = last_addr;
    next_last_bit = last_bit;
    next_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rdata = rsp_rdata_out;
    next_done = 1'b0;
    next_err = 1'b0;
    next_addr = mem_addr_out;
    next_ce_n = chip_en_n_out;
    next_oe_n = out_en_n_out;
    next_we_n = write_en_n_out;
    next_hv = erase_hv_out;
    next_dout = mem_data_out;
    next_doe = mem_data_oe_out;
    if (loading && blc_cnt != '0)
      next_blc_cnt = blc_cnt - 1'b1;
    case (state)
      PEE_IDLE:
      begin
        next_ready = 1'b1;
        // a take wins: ready already stood high, so it cannot be dropped
        if (req_valid_in && req_ready_out)
        begin
          next_ready = 1'b0;
          next_addr = req_addr_in;
          next_ce_n = 1'b0;
          if (req_erase_in)
          begin
            // high voltage on output enable first
            next_hv = 1'b1;
            next_oe_n = 1'b1;
            next_cnt = CNT_W'(ERSH_CYC);
            next_state = PEE_ER_SETUP;
          end
          else if (req_write_in && page_ok)
          begin
            next_oe_n = 1'b1;
            next_we_n = 1'b0;
            next_dout = req_wdata_in;
            next_doe = 1'b1;
            next_page = req_addr_in[ADDR_W-1:PAGE_LSB];
            next_last_addr = req_addr_in;
            next_last_bit = req_wdata_in[POLL_BIT];
            next_cnt = CNT_W'(WP_CYC);
            next_state = PEE_WR_LOW;
            next_loading = !req_last_in;
          end
          else if (req_write_in)
          begin
            // off-page byte refused
            next_ce_n = 1'b1;
            next_err = 1'b1;
            next_ready = 1'b1;
          end
          else
          begin
            next_oe_n = 1'b0;
            next_cnt = CNT_W'(ACC_CYC);
            next_state = PEE_RD_WAIT;
          end
        end
        // window margin spent, end load and poll
        else if (loading && blc_cnt == '0)
        begin
          next_ready = 1'b0;
          next_state = PEE_POLL_LOW;
          next_poll_cnt = '0;
        end
      end
      PEE_RD_WAIT:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_rdata = pin_data;
          next_rsp_valid = 1'b1;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = PEE_IDLE;
        end
      end
      PEE_WR_LOW:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_we_n = 1'b1;
          next_cnt = CNT_W'(WPH_CYC);
          next_state = PEE_WR_HIGH;
        end
      end
      PEE_WR_HIGH:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_doe = 1'b0;
          next_ce_n = 1'b1;
          if (loading)
          begin
            next_blc_cnt = CNT_W'(BLC_CYCLES - 40);
            next_state = PEE_IDLE;
          end
          else
          begin
            next_poll_cnt = '0;
            next_state = PEE_POLL_LOW;
          end
        end
      end
      PEE_POLL_LOW:
      begin
        next_loading = 1'b0;
        next_addr = last_addr;
        next_ce_n = 1'b0;
        next_oe_n = 1'b0;
        next_cnt = CNT_W'(ACC_CYC);
        next_state = PEE_POLL_CHK;
      end
      PEE_POLL_CHK:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_poll_cnt = poll_cnt + 1'b1;
          if (pin_data[POLL_BIT] == last_bit)
          begin
            next_done = 1'b1;
            next_state = PEE_IDLE;
          end
          else if (poll_cnt >= 32'(POLL_LIMIT))
          begin
            next_err = 1'b1;
            next_state = PEE_IDLE;
          end
          else
            next_state = PEE_POLL_LOW;
        end
      end
      PEE_ER_SETUP:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_we_n = 1'b0;
          next_cnt = CNT_W'(ERASE_CYCLES);
          next_state = PEE_ER_LOW;
        end
      end
      PEE_ER_LOW:
      begin
        // write enable low for erase time
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_we_n = 1'b1;
          next_cnt = CNT_W'(ERSH_CYC);
          next_state = PEE_ER_HOLD;
        end
      end
      PEE_ER_HOLD:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0)
        begin
          next_hv = 1'b0;
          next_ce_n = 1'b1;
          next_done = 1'b1;
          next_state = PEE_IDLE;
        end
      end
      default:
        next_state = PEE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= PEE_IDLE;
      cnt <= '0;
      blc_cnt <= '0;
      poll_cnt <= '0;
      loading <= 1'b0;
      page <= '0;
      last_addr <= '0;
      last_bit <= 1'b0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
      wr_done_out <= 1'b0;
      err_out <= 1'b0;
      mem_addr_out <= '0;
      chip_en_n_out <= 1'b1;
      out_en_n_out <= 1'b1;
      write_en_n_out <= 1'b1;
      erase_hv_out <= 1'b0;
      mem_data_out <= '0;
      mem_data_oe_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      blc_cnt <= next_blc_cnt;
      poll_cnt <= next_poll_cnt;
      loading <= next_loading;
      page <= next_page;
      last_addr <= next_last_addr;
      last_bit <= next_last_bit;
      req_ready_out <= next_ready;
      rsp_valid_out <= next_rsp_valid;
      rsp_rdata_out <= next_rdata;
      wr_done_out <= next_done;
      err_out <= next_err;
      mem_addr_out <= next_addr;
      chip_en_n_out <= next_ce_n;
      out_en_n_out <= next_oe_n;
      write_en_n_out <= next_we_n;
      erase_hv_out <= next_hv;
      mem_data_out <= next_dout;
      mem_data_oe_out <= next_doe;
    end
  end
endmodule

/* sim/pee_eeprom_model.sv */
// behavioural paged eeprom seen from its pins
`timescale 1ns/10ps
module pee_eeprom_model
  import pee_pkg::*;
#(
  parameter int BLC = 3000,
  parameter int PROG = 300,
  parameter int ERASE_N = 200000
)
(
  // clock for internal timers
  input wire logic clk_in,
  // pins
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic hv_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last_d = 8'h00;
  logic [DATA_W-1:0] flt = 8'h3c;
  logic loading = 1'h0;
  logic armed = 1'h0;
  int idle = 0;
  int busy = 0;
  int er = 0;
  wire stb_n = ce_n_in | we_n_in;
  initial
    for (int i = 0; i < (1<<ADDR_W); i++)
      mem[i] = i[7:0] ^ 8'h5a;
  // power-up x to 1 must not count as a strobe
  always @(negedge stb_n)
    armed = 1'h1;
  always @(posedge stb_n)
  begin
    if (armed && oe_n_in && !hv_in && busy == 0)
    begin
      mem[addr_in] = data_in;
      last_d = data_in;
      loading = 1'h1;
      idle = 0;
    end
    armed = 1'h0;
  end
  always @(posedge clk_in)
  begin
    flt <= ~flt;
    idle <= idle + 1;
    if (loading && idle >= BLC)
    begin
      loading <= 1'h0;
      busy <= PROG;
    end
    else if (busy > 0)
      busy <= busy - 1;
    if (!ce_n_in && !we_n_in && hv_in)
      er <= er + 1;
    else if (er > 0)
    begin
      if (er >= ERASE_N)
        foreach (mem[i]) mem[i] = 8'hff;
      er <= 0;
    end
  end
  always_comb
    if (!ce_n_in && !oe_n_in && we_n_in)
      data_out = (busy > 0 || loading) ? {~last_d[7], flt[6:0]} : mem[addr_in];
    else
      data_out = flt;
endmodule

/* sim/pee_host_asserts.sv */
// port assertions for the eeprom host
`timescale 1ns/10ps
module pee_host_asserts
  import pee_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
)
(
  // clock, reset, requests
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_erase_in,
  input wire logic req_ready_out,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic rsp_valid_out,
  input wire logic err_out,
  // pins
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic chip_en_n_out,
  input wire logic out_en_n_out,
  input wire logic write_en_n_out,
  input wire logic erase_hv_out,
  input wire logic mem_data_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic in_load;
  logic [ADDR_W-PAGE_LSB-1:0] pg;
  int gap;
  int er;
  wire take = req_valid_in && req_ready_out;
  wire stb_n = chip_en_n_out | write_en_n_out;
  // load stays open from first strobe until output enable goes low or erase high voltage rises
  always_ff @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in)
    begin
      in_load <= 1'h0;
      pg <= '0;
      gap <= 0;
      er <= 0;
    end
    else
    begin
      in_load <= out_en_n_out && !erase_hv_out && (in_load || !stb_n);
      if (!in_load)
        pg <= mem_addr_out[ADDR_W-1:PAGE_LSB];
      gap <= stb_n ? gap + 1 : 0;
      er <= !erase_hv_out ? 0 : er + int'(!write_en_n_out);
    end
  sequence rd_pins;
    !chip_en_n_out && !out_en_n_out && write_en_n_out;
  endsequence
  page_hold_a: assert property ($fell(stb_n) && in_load
    |-> mem_addr_out[ADDR_W-1:PAGE_LSB] == pg) else $error("page changed in load");
  offpage_err_a: assert property (take && req_write_in && !req_erase_in && in_load
    && req_addr_in[ADDR_W-1:PAGE_LSB] != pg |-> ##[1:4] err_out) else $error("no refusal");
  oe_high_write_a: assert property (!stb_n |-> out_en_n_out || erase_hv_out)
    else $error("oe low in strobe");
  load_gap_a: assert property (in_load |-> gap < BLC_CYCLES)
    else $error("byte load gap too long");
  erase_ce_a: assert property (erase_hv_out && !write_en_n_out |-> !chip_en_n_out)
    else $error("erase without chip enable");
  erase_len_a: assert property ($rose(write_en_n_out) && erase_hv_out
    |-> er >= ERASE_CYCLES) else $error("erase strobe short");
  rd_walk_a: assert property (take && !req_write_in && !req_erase_in
    |-> ##1 rd_pins[*5] ##[1:2] rsp_valid_out) else $error("read walk wrong");
  rd_addr_a: assert property (take && !req_write_in && !req_erase_in
    |=> mem_addr_out == $past(req_addr_in)) else $error("read address wrong");
  no_contend_a: assert property (!out_en_n_out && !erase_hv_out |-> !mem_data_oe_out)
    else $error("host drives during read");
endmodule
bind pee_host pee_host_asserts #(.BLC_CYCLES(BLC_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk_i (.*);

/* sim/pee_host_bench.sv */
// self-checking bench for the eeprom host
`timescale 1ns/10ps
module pee_host_bench;
  import pee_pkg::*;
  logic clk_sys_in = 1'h0;
  logic resetn_in = 1'h0;
  logic req_valid_in = 1'h0, req_write_in = 1'h0, req_last_in = 1'h0, req_erase_in = 1'h0;
  logic [ADDR_W-1:0] req_addr_in = 15'h0;
  logic [DATA_W-1:0] req_wdata_in = 8'h0;
  logic req_ready_out, rsp_valid_out, wr_done_out, err_out, erase_hv_out;
  logic chip_en_n_out, out_en_n_out, write_en_n_out, mem_data_oe_out;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [DATA_W-1:0] rsp_rdata_out, mem_data_out, dev_data, mem_data_in;
  logic [DATA_W-1:0] exp_mem [0:(1<<ADDR_W)-1];
  int err_count = 0, cmp_count = 0, cyc = 0;
  // short window and erase keep the run brief
  pee_host #(.BLC_CYCLES(100), .ERASE_CYCLES(50), .POLL_LIMIT(1000)) uut (.*);
  pee_eeprom_model #(.BLC(100), .PROG(300), .ERASE_N(50)) dev (.clk_in(clk_sys_in),
    .addr_in(mem_addr_out), .ce_n_in(chip_en_n_out), .oe_n_in(out_en_n_out),
    .we_n_in(write_en_n_out), .hv_in(erase_hv_out), .data_in(mem_data_in),
    .data_out(dev_data));
  assign mem_data_in = mem_data_oe_out ? mem_data_out : dev_data;
  initial
    forever #25 clk_sys_in = ~clk_sys_in;
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string w, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic req(input logic w, l, er, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req_valid_in <= 1'h1;
    req_write_in <= w;
    req_last_in <= l;
    req_erase_in <= er;
    req_addr_in <= a;
    req_wdata_in <= d;
    do @(posedge clk_sys_in); while (req_ready_out !== 1'h1);
    req_valid_in <= 1'h0;
  endtask
  task automatic wait_hi(input string w, ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'h1; n++)
      @(posedge clk_sys_in);
    chk(w, 8'h1, {7'h0, s});
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    req(1'h0, 1'($urandom), 1'h0, a, 8'($urandom));
    wait_hi("rsp", rsp_valid_out, 12);
    chk("rdata", exp_mem[a], rsp_rdata_out);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic l);
    logic [DATA_W-1:0] d;
    d = DATA_W'($urandom);
    req(1'h1, l, 1'h0, a, d);
    exp_mem[a] = d;
  endtask
  initial
  begin
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] q[$];
    int n;
    void'($urandom(32'h1a7e));
    for (int i = 0; i < (1<<ADDR_W); i++)
      exp_mem[i] = i[7:0] ^ 8'h5a;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    // odd passes close by last flag, even ones by window timeout
    for (int k = 0; k < 8; k++)
    begin
      n = 1 + $urandom % 5;
      a = ADDR_W'($urandom);
      q = {};
      for (int j = 0; j < n; j++)
      begin
        a[5:0] = (j == 0) ? 6'h3f : 6'($urandom);
        q.push_back(a);
        wr(a, k[0] && j == n - 1);
        if (k == 2 && j == 0)
        begin
          req(1'h1, 1'h0, 1'h0, a ^ 15'h0040, 8'ha5);
          wait_hi("err", err_out, 6);
          q.push_back(a ^ 15'h0040);
        end
      end
      wait_hi("done", wr_done_out, 3000);
      foreach (q[j]) rd(q[j]);
      rd(ADDR_W'($urandom));
    end
    req(1'($urandom), 1'($urandom), 1'h1, 15'($urandom), 8'($urandom));
    wait_hi("erase", wr_done_out, 600);
    foreach (exp_mem[i]) exp_mem[i] = 8'hff;
    rd(ADDR_W'($urandom));
    end_of_test();
  end
endmodule
